// >>> design/ssmf_regs.svh
`ifndef SSMF_REGS_SVH
`define SSMF_REGS_SVH
// Frame width in bits
`define SSMF_FRAME_BITS 8
// Bit counter width
`define SSMF_CNT_W 3
// Reset values of the control bits
`define SSMF_RST_MASTER 1'b0
`define SSMF_RST_FLAG 1'b0
// Width of one data word
`define SSMF_DATA_W 8
`endif

// >>> design/ssmf_pkg.sv
package ssmf_pkg;
  typedef logic [7:0] ssmf_byte_t;
  // Slave-side shift state, Gray coded along idle -> shift -> done
  typedef enum logic [1:0] {SSMF_IDLE = 2'b00, SSMF_SHIFT = 2'b01, SSMF_DONE = 2'b11} ssmf_state_e;
endpackage : ssmf_pkg

// >>> design/ssmf_buf_if.sv
`timescale 1ns/1ps
`default_nettype none
// Word stream between the receive engine and the two-entry buffer
interface ssmf_buf_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ssmf_buf_if
`default_nettype wire

// >>> design/ssmf_buf.sv
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer; drain side can stall so back-pressure reaches the source
module ssmf_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  ssmf_buf_if.snk in_if,
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [1:0] cnt_ff, nxt_cnt;
  logic wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic push, pop;

  // Handshakes on both sides
  assign in_if.ready = (cnt_ff < 2'(DEPTH));
  assign o_valid = (cnt_ff != 2'h0);
  assign o_data = mem_ff[rp_ff];
  assign push = in_if.valid && in_if.ready && i_ce;
  assign pop = o_valid && i_ready && i_ce;

  // Pointer and count next state
  always_comb
  begin
    nxt_cnt = cnt_ff + 2'(push) - 2'(pop);
    nxt_wp = push ? ~wp_ff : wp_ff;
    nxt_rp = pop ? ~rp_ff : rp_ff;
  end

  // Pointer registers
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt_ff <= 2'h0;
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
    end
  end

  // Storage has no reset; only written on push
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem_ff[wp_ff] <= in_if.data;
    end
  end
endmodule : ssmf_buf
`default_nettype wire

// >>> design/ssmf_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssmf_regs.svh"
// Operation
// - Master drives the shift clock pin; slave takes it as an input.
// - Master-select bit sets MISO and MOSI directions; like pins interconnect.
// - Slave, select honoured, SS low: activate; MISO may drive, rest inputs.
// - Slave, select honoured, SS high: all pins inputs, no data accepted.
// - SS rising in slave mode resets bit counter, drops partial bits.
// - Select-ignore set in slave mode: ignore SS, three-wire, always enabled.
// - Slave-output-disable set: slave never drives MISO.
// - Master with select-ignore set: SS is a plain output only.
// - SS low while master, select-ignore clear: drop to slave, release pins.
// - Mode fault sets the mode fault flag and interrupt if enabled.
// - Master-select stays cleared after fault until software sets it again.
// - End of byte: set transfer-complete, move byte to receive buffer, interrupt; the flag is not set if the buffer is full.
// - Port enabled: pin directions follow master-select without software setup; MISO drive also needs I_MISO_OUT_CFG set.
module ssmf_core
  import ssmf_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic I_CE,
  input wire logic I_SCK_CLK,
  input wire logic I_PORT_ENABLE,
  input wire logic I_MASTER_SET,
  input wire logic I_SELECT_IGNORE,
  input wire logic I_SLAVE_OUTPUT_DISABLE,
  input wire logic I_MISO_OUT_CFG,
  input wire logic I_INT_ENABLE,
  input wire logic I_FAULT_CLEAR,
  input wire logic I_DONE_CLEAR,
  input wire logic I_SCK_MASTER,
  input wire logic I_MOSI_MASTER,
  input wire logic I_SS_GPIO,
  input wire logic I_SS_N,
  input wire logic I_MOSI,
  input wire logic I_RX_READY,
  output logic O_MASTER_SELECT,
  output logic O_SLAVE_ACTIVE,
  output logic O_SHIFT_RESET,
  output logic O_MODE_FAULT,
  output logic O_XFER_DONE,
  output logic O_IRQ,
  output logic O_SCK_OUT,
  output logic O_SCK_OE,
  output logic O_MOSI_OUT,
  output logic O_MOSI_OE,
  output logic O_MISO_OUT,
  output logic O_MISO_OE,
  output logic O_SS_OUT,
  output logic O_SS_OE,
  output logic O_RX_VALID,
  output logic [`SSMF_DATA_W-1:0] O_RX_DATA
);
  // System-domain state
  logic ss_m_ff, ss_s_ff, ss_d_ff;
  logic master_ff, nxt_master;
  logic fault_ff, nxt_fault;
  logic done_ff, nxt_done;
  logic ss_low, ss_rise, fault_ev, slave_en;
  // Slave enable, registered so no combinational glitch reaches the link reset
  logic en_src_ff, nxt_en_src, link_rstn;
  // Crossing of the slave enable into the link domain
  logic en_m_ff, en_s_ff;
  // Link-domain state
  logic [`SSMF_CNT_W-1:0] cnt_ff, nxt_cnt;
  ssmf_byte_t sh_ff, nxt_sh;
  ssmf_byte_t word_ff, nxt_word;
  logic tog_ff, nxt_tog;
  ssmf_state_e st_ff, nxt_st;
  // Toggle synchroniser back into the system domain
  logic tog_m_ff, tog_s_ff, tog_d_ff;
  ssmf_byte_t hold_ff, nxt_hold;
  logic pend_ff, nxt_pend;
  logic word_ev;
  ssmf_buf_if bif ();

  // two-stage sync
  // Only the second stage and its delayed copy feed decisions
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      ss_m_ff <= 1'b1;
      ss_s_ff <= 1'b1;
      ss_d_ff <= 1'b1;
      tog_m_ff <= 1'b0;
      tog_s_ff <= 1'b0;
      tog_d_ff <= 1'b0;
    end
    else if (I_CE)
    begin
      ss_m_ff <= I_SS_N;
      ss_s_ff <= ss_m_ff;
      ss_d_ff <= ss_s_ff;
      tog_m_ff <= tog_ff;
      tog_s_ff <= tog_m_ff;
      tog_d_ff <= tog_s_ff;
    end
  end

  assign ss_low = !ss_s_ff;
  assign ss_rise = ss_s_ff && !ss_d_ff;
  assign fault_ev = I_PORT_ENABLE && master_ff && !I_SELECT_IGNORE && ss_low;
  assign slave_en = I_PORT_ENABLE && !master_ff && (I_SELECT_IGNORE || ss_low);
  assign word_ev = tog_s_ff ^ tog_d_ff;

  // Control and flag next state; hardware set wins over software clear
  always_comb
  begin
    nxt_master = master_ff;
    if (I_MASTER_SET)
    begin
      nxt_master = 1'b1;
    end
    if (fault_ev)
    begin
      nxt_master = 1'b0;
    end
    nxt_fault = fault_ev ? 1'b1 : (I_FAULT_CLEAR ? 1'b0 : fault_ff);
    nxt_done = (word_ev && bif.ready) ? 1'b1 : (I_DONE_CLEAR ? 1'b0 : done_ff);
    nxt_hold = word_ev ? word_ff : hold_ff;
    nxt_pend = word_ev ? 1'b1 : ((pend_ff && bif.ready) ? 1'b0 : pend_ff);
    nxt_en_src = slave_en;
  end

  // Control registers
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      master_ff <= `SSMF_RST_MASTER;
      fault_ff <= `SSMF_RST_FLAG;
      done_ff <= `SSMF_RST_FLAG;
      hold_ff <= 8'h00;
      pend_ff <= 1'b0;
      en_src_ff <= 1'b0;
    end
    else if (I_CE)
    begin
      master_ff <= nxt_master;
      fault_ff <= nxt_fault;
      done_ff <= nxt_done;
      hold_ff <= nxt_hold;
      pend_ff <= nxt_pend;
      en_src_ff <= nxt_en_src;
    end
  end

  // Received word enters the buffer; a full buffer holds it pending
  assign bif.valid = pend_ff;
  assign bif.data = hold_ff;

  ssmf_buf #(
    .WIDTH(`SSMF_DATA_W),
    .DEPTH(2)
  ) u_buf (
    .i_clk(I_REF_CLK),
    .i_rstn(I_RSTN),
    .i_ce(I_CE),
    .in_if(bif),
    .o_valid(O_RX_VALID),
    .o_data(O_RX_DATA),
    .i_ready(I_RX_READY)
  );

  // Status outputs
  assign O_MASTER_SELECT = master_ff;
  assign O_SLAVE_ACTIVE = slave_en;
  assign O_MODE_FAULT = fault_ff;
  assign O_XFER_DONE = done_ff;
  assign O_SHIFT_RESET = ss_rise && !master_ff && !I_SELECT_IGNORE;
  assign O_IRQ = I_INT_ENABLE && (fault_ff || done_ff);

  assign O_SCK_OUT = I_SCK_MASTER;
  assign O_SCK_OE = I_PORT_ENABLE && master_ff;
  assign O_MOSI_OUT = I_MOSI_MASTER;
  assign O_MOSI_OE = I_PORT_ENABLE && master_ff;
  // MISO only while slave active and allowed
  assign O_MISO_OUT = sh_ff[7];
  assign O_MISO_OE = slave_en && I_MISO_OUT_CFG && !I_SLAVE_OUTPUT_DISABLE;
  assign O_SS_OUT = I_SS_GPIO;
  assign O_SS_OE = I_PORT_ENABLE && master_ff && I_SELECT_IGNORE;

  // deselect reaches the link side at once
  // The shift clock stops between frames, so a sampled enable would never see
  // the deselect; the drop resets the link side and is released in step
  assign link_rstn = I_RSTN && en_src_ff;

  // Reset synchroniser: asserts at once, releases after two link edges
  always_ff @(posedge I_SCK_CLK or negedge link_rstn)
  begin
    if (!link_rstn)
    begin
      en_m_ff <= 1'b0;
      en_s_ff <= 1'b0;
    end
    else
    begin
      en_m_ff <= 1'b1;
      en_s_ff <= en_m_ff;
    end
  end

  // Link-side shift engine next state
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_word = word_ff;
    nxt_tog = tog_ff;
    nxt_st = st_ff;
    unique case (st_ff)
      SSMF_IDLE:
      begin
        nxt_cnt = '0;
        if (en_s_ff)
        begin
          nxt_st = SSMF_SHIFT;
        end
      end
      SSMF_SHIFT:
      begin
        nxt_sh = {sh_ff[6:0], I_MOSI};
        nxt_cnt = cnt_ff + 3'h1;
        if (cnt_ff == 3'(`SSMF_FRAME_BITS - 1))
        begin
          nxt_word = {sh_ff[6:0], I_MOSI};
          nxt_tog = ~tog_ff;
          nxt_st = SSMF_DONE;
        end
      end
      SSMF_DONE:
      begin
        nxt_cnt = '0;
        nxt_st = SSMF_SHIFT;
      end
    endcase
    // passive when deselected: partial bits dropped
    if (!en_s_ff)
    begin
      nxt_st = SSMF_IDLE;
      nxt_cnt = '0;
      nxt_sh = 8'h00;
    end
  end

  // bit count and partial bits cleared on deselect
  always_ff @(posedge I_SCK_CLK or negedge link_rstn)
  begin
    if (!link_rstn)
    begin
      cnt_ff <= '0;
      sh_ff <= 8'h00;
      st_ff <= SSMF_IDLE;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      st_ff <= nxt_st;
    end
  end

  // Word and toggle survive a deselect; a reset toggle would fake a word
  always_ff @(posedge I_SCK_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      word_ff <= 8'h00;
      tog_ff <= 1'b0;
    end
    else
    begin
      word_ff <= nxt_word;
      tog_ff <= nxt_tog;
    end
  end

  // Fault demotes master next cycle
  fault_drop_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    I_CE && fault_ev |=> !master_ff)
    else $error("master kept after fault");

  // Fault sets flag
  fault_flag_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    I_CE && fault_ev |=> fault_ff)
    else $error("fault flag not set");

  // Master stays cleared without a set
  master_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    I_CE && !master_ff && !I_MASTER_SET |=> !master_ff)
    else $error("master returned alone");

  // MISO never driven when disabled
  miso_off_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    I_SLAVE_OUTPUT_DISABLE |-> !O_MISO_OE)
    else $error("miso driven while disabled");

  // Deselected slave drives nothing
  slave_quiet_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    !master_ff && !I_SELECT_IGNORE && ss_s_ff |-> !O_MISO_OE && !O_SCK_OE && !O_MOSI_OE)
    else $error("deselected slave drives a pin");

  // Clock pin driven only as enabled master
  sck_dir_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    O_SCK_OE == (I_PORT_ENABLE && master_ff))
    else $error("clock pin direction wrong");

  // Three-wire slave active regardless of select
  three_wire_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    I_PORT_ENABLE && !master_ff && I_SELECT_IGNORE |-> O_SLAVE_ACTIVE)
    else $error("three-wire slave inactive");

  // Select rise pulses the shift reset for one cycle
  desel_rst_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    I_CE && O_SHIFT_RESET |=> !O_SHIFT_RESET)
    else $error("shift reset not a pulse");

  // Word arrival sets completion flag
  done_set_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    I_CE && word_ev && bif.ready |=> done_ff)
    else $error("completion flag missed");

  // Fault releases clock and data pins next cycle
  fault_pins_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    I_CE && fault_ev |=> !O_SCK_OE && !O_MOSI_OE)
    else $error("pins driven after fault");

  // Software clear without a new word drops the completion flag
  done_clear_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    I_CE && I_DONE_CLEAR && !word_ev |=> !done_ff)
    else $error("completion flag not cleared");

  // Deselect pulse puts the link side into reset next cycle
  desel_link_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    I_CE && O_SHIFT_RESET |=> !link_rstn)
    else $error("link side not reset on deselect");
endmodule : ssmf_core
`default_nettype wire

// >>> test/ssmf_far_master.sv
`timescale 1ns/1ps
`default_nettype none
// Far-end SPI master; its shift clock runs only inside a frame
module ssmf_far_master (
  output logic o_ss_n,
  output logic o_sck,
  output logic o_mosi
);
  logic busy;
  initial
  begin
    o_ss_n = 1'b1;
    o_sck = 1'b0;
    o_mosi = 1'b0;
    busy = 1'b0;
  end
  // Released data line keeps toggling so a stale bit never looks valid
  always #50 if (!busy) o_mosi = ~o_mosi;
  task automatic sel(input logic lvl);
    o_ss_n = lvl;
    #200;
  endtask : sel
  // Lead edges let the enable cross; then n bits MSB first, rising edge samples
  task automatic send(input logic [7:0] b, input int n);
    int i;
    busy = 1'b1;
    #3;
    for (i = -3; i < n; i++)
    begin
      o_mosi = (i < 0) ? 1'b0 : b[7-i];
      #80 o_sck = 1'b1;
      #80 o_sck = 1'b0;
    end
    busy = 1'b0;
  endtask : send
endmodule : ssmf_far_master
`default_nettype wire

// >>> test/spi_select_and_mode_fault_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spi_select_and_mode_fault_tb;
  import ssmf_pkg::*;
  logic clk, rstn, pen, mset, select_ignore_bit, sod, ien, fclr, dclr, rdy, ss_gpio;
  logic ce, miso_cfg, sck_m, mosi_m;
  logic p_ss_n, p_sck, p_mosi, ms, sact, shrst, mf, xd, irq, rxv;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
  logic ss_pin, sck_pin, mosi_pin;
  ssmf_byte_t rxd, b;
  ssmf_byte_t expq[$];
  int miscompares = 0, n_compared = 0;
  int n_shrst = 0;
  // Pin levels resolved from the core's enables; the far end drives otherwise
  assign ss_pin = ss_oe ? ss_o : p_ss_n;
  assign sck_pin = sck_oe ? sck_o : p_sck;
  assign mosi_pin = mosi_oe ? mosi_o : p_mosi;
  ssmf_core ssmf_core_i (.I_REF_CLK(clk), .I_RSTN(rstn), .I_CE(ce), .I_SCK_CLK(sck_pin),
    .I_PORT_ENABLE(pen), .I_MASTER_SET(mset), .I_SELECT_IGNORE(select_ignore_bit), .I_SLAVE_OUTPUT_DISABLE(sod),
    .I_MISO_OUT_CFG(miso_cfg), .I_INT_ENABLE(ien), .I_FAULT_CLEAR(fclr), .I_DONE_CLEAR(dclr),
    .I_SCK_MASTER(sck_m), .I_MOSI_MASTER(mosi_m), .I_SS_GPIO(ss_gpio), .I_SS_N(ss_pin),
    .I_MOSI(mosi_pin), .I_RX_READY(rdy), .O_MASTER_SELECT(ms), .O_SLAVE_ACTIVE(sact),
    .O_SHIFT_RESET(shrst), .O_MODE_FAULT(mf), .O_XFER_DONE(xd), .O_IRQ(irq), .O_SCK_OUT(sck_o),
    .O_SCK_OE(sck_oe), .O_MOSI_OUT(mosi_o), .O_MOSI_OE(mosi_oe), .O_MISO_OUT(miso_o),
    .O_MISO_OE(miso_oe), .O_SS_OUT(ss_o), .O_SS_OE(ss_oe), .O_RX_VALID(rxv), .O_RX_DATA(rxd));
  ssmf_far_master ssmf_far_master_i (.o_ss_n(p_ss_n), .o_sck(p_sck), .o_mosi(p_mosi));
  // Reference clock, 8 ns
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Deselect pulses counted at the edge that consumes them
  always @(posedge clk)
    if (shrst === 1'b1)
      n_shrst++;
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    $display("Compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  // Bounded wait for a flag; running out counts and ends the run
  task automatic wait_sig(input string nm, ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    chk(nm, 8'(s), 8'(v));
    if (s !== v) test_done();
  endtask : wait_sig
  task automatic drain;
    int n;
    n = 0;
    while (expq.size() > 0 && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    chk("queue left", 8'(expq.size()), 8'h00);
    if (expq.size() > 0) test_done();
  endtask : drain
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  // Each word leaving the buffer is matched against the oldest note
  always @(posedge clk)
    if (rxv === 1'b1 && rdy === 1'b1)
      chk("rx_data", rxd, (expq.size() > 0) ? expq.pop_front() : 8'hxx);
  // Main sequence
  initial
  begin
    rstn = 1'b0;
    pen = 1'b1;
    mset = 1'b0;
    select_ignore_bit = 1'b0;
    sod = 1'b0;
    ien = 1'b1;
    fclr = 1'b0;
    dclr = 1'b0;
    rdy = 1'b1;
    ss_gpio = 1'b1;
    ce = 1'b1;
    miso_cfg = 1'b1;
    sck_m = 1'b0;
    mosi_m = 1'b0;
    void'($urandom(15416));
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk("sck_oe", 8'(sck_oe), 8'h00);
    chk("miso_oe idle", 8'(miso_oe), 8'h00);
    // Stalled drain: three framed bytes, buffer full plus one pending
    rdy = 1'b0;
    repeat (3)
    begin
      b = 8'($urandom);
      expq.push_back(b);
      ssmf_far_master_i.sel(1'b0);
      chk("miso_oe sel", 8'(miso_oe), 8'h01);
      chk("mosi_oe sel", 8'(mosi_oe), 8'h00);
      chk("slave_active sel", 8'(sact), 8'h01);
      ssmf_far_master_i.send(b, 8);
      ssmf_far_master_i.sel(1'b1);
    end
    chk("xfer_done", 8'(xd), 8'h01);
    @(negedge clk);
    rdy = 1'b1;
    drain();
    // Partial byte dropped on deselect, next full byte aligned
    ssmf_far_master_i.sel(1'b0);
    ssmf_far_master_i.send(8'($urandom), 5);
    ssmf_far_master_i.sel(1'b1);
    chk("slave_active desel", 8'(sact), 8'h00);
    b = 8'($urandom);
    expq.push_back(b);
    ssmf_far_master_i.sel(1'b0);
    ssmf_far_master_i.send(b, 8);
    ssmf_far_master_i.sel(1'b1);
    drain();
    // Three-wire slave with SS high, output disabled then enabled
    @(negedge clk);
    select_ignore_bit = 1'b1;
    sod = 1'b1;
    b = 8'($urandom);
    expq.push_back(b);
    ssmf_far_master_i.send(b, 8);
    drain();
    chk("miso_oe disabled", 8'(miso_oe), 8'h00);
    @(negedge clk);
    sod = 1'b0;
    repeat (4) @(negedge clk);
    chk("miso_oe three-wire", 8'(miso_oe), 8'h01);
    chk("miso_out three-wire", 8'(miso_o), 8'(b[7]));
    miso_cfg = 1'b0;
    @(negedge clk);
    chk("miso_oe unconfigured", 8'(miso_oe), 8'h00);
    miso_cfg = 1'b1;
    // Mode fault: master, select honoured, SS pulled low
    select_ignore_bit = 1'b0;
    pulse(dclr);
    // SS held high while master until the collision below
    pulse(mset);
    wait_sig("master", ms, 1'b1);
    chk("done cleared", 8'(xd), 8'h00);
    chk("sck_oe master", 8'(sck_oe), 8'h01);
    chk("miso_oe master", 8'(miso_oe), 8'h00);
    ssmf_far_master_i.sel(1'b0);
    wait_sig("mode_fault", mf, 1'b1);
    chk("master after fault", 8'(ms), 8'h00);
    chk("sck_oe fault", 8'(sck_oe), 8'h00);
    chk("irq", 8'(irq), 8'h01);
    ssmf_far_master_i.sel(1'b1);
    ien = 1'b0;
    @(negedge clk);
    chk("irq masked", 8'(irq), 8'h00);
    pulse(fclr);
    repeat (5) @(negedge clk);
    chk("fault cleared", 8'(mf), 8'h00);
    chk("master stays", 8'(ms), 8'h00);
    // Frozen clock enable lets no software set land
    ce = 1'b0;
    pulse(mset);
    @(negedge clk);
    chk("master frozen", 8'(ms), 8'h00);
    ce = 1'b1;
    // Single master: SS is a plain output, low level causes no fault
    select_ignore_bit = 1'b1;
    ss_gpio = 1'b0;
    pulse(mset);
    wait_sig("master single", ms, 1'b1);
    repeat (10) @(negedge clk);
    chk("ss_oe", 8'(ss_oe), 8'h01);
    chk("ss_out", 8'(ss_o), 8'h00);
    chk("no fault", 8'(mf), 8'h00);
    sck_m = 1'($urandom);
    mosi_m = 1'($urandom);
    @(negedge clk);
    chk("sck_out", 8'(sck_o), 8'(sck_m));
    chk("mosi_out", 8'(mosi_o), 8'(mosi_m));
    chk("mosi_oe master", 8'(mosi_oe), 8'h01);
    pen = 1'b0;
    @(negedge clk);
    chk("sck_oe disabled", 8'(sck_oe), 8'h00);
    chk("shift_reset pulses", 8'(n_shrst), 8'h06);
    test_done();
  end
endmodule : spi_select_and_mode_fault_tb
`default_nettype wire
